/* File: hdl/sec_dog_pkg.sv */
package sec_dog_pkg;

   // Register byte addresses on the Avalon-MM slave.
   localparam logic [3:0] ADDR_COMMAND  = 4'h8;
   localparam logic [3:0] ADDR_PERIOD   = 4'hC;
   localparam logic [3:0] ADDR_STATUS   = 4'h0;
   localparam logic [3:0] ADDR_MASK     = 4'h4;

   // Command codes for the watchdog command register.
   localparam logic [7:0] CMD_SEC_RESTART = 8'h5F;
   localparam logic [7:0] CMD_PRI_2S      = 8'h5A;
   localparam logic [7:0] CMD_PRI_1S      = 8'h57;
   localparam logic [7:0] CMD_PRI_500MS   = 8'h59;
   localparam logic [7:0] CMD_PRI_250MS   = 8'h53;

   // Disable sequence written to the period constant register.
   localparam logic [7:0] OFF_KEY_1 = 8'h5A;
   localparam logic [7:0] OFF_KEY_2 = 8'h52;
   localparam logic [7:0] OFF_KEY_3 = 8'h44;

   // Primary time-out selectors handed to the primary watchdog.
   localparam logic [1:0] PRI_SEL_2S    = 2'h0;
   localparam logic [1:0] PRI_SEL_1S    = 2'h1;
   localparam logic [1:0] PRI_SEL_500MS = 2'h2;
   localparam logic [1:0] PRI_SEL_250MS = 2'h3;

   // Reset values and status bit positions.
   localparam logic [7:0] PERIOD_RESET = 8'h00;
   localparam int         STAT_EXPIRE  = 0;
   localparam int         STAT_OFF     = 1;
   localparam logic [2:0] IRQ_LEVEL    = 3'h3;

   // Tick rate: 32.768 kHz derived from the 40 MHz clock by a fractional step.
   localparam int          CLK_HZ      = 40000000;
   localparam int          TICK_HZ     = 32768;
   localparam logic [31:0] TICK_STEP   = 32'(TICK_HZ);
   localparam logic [31:0] TICK_MODULO = 32'(CLK_HZ);

   // Disable sequence progress.
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_ONE  = 3'b010,
      SEQ_TWO  = 3'b100
   } seq_state_t;

endpackage

/* File: hdl/secondary_dog_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// Operation
// - The timer is an eight-bit down counter, modulo n+1, stepped by a 32.768 kHz tick.
// - After reset the timer is off and requests no interrupt.
// - Writing 0x5F to the command register switches the timer on.
// - Writing 0x5F while counting restarts the count so no interrupt fires for that period.
// - Reaching zero without a restart raises an interrupt at priority level 3.
// - A new period constant takes effect at the next reach of zero or the next 0x5F restart.
// - Constants 0 to 255 give periods from about 30.5 us to about 7.8 ms.
// - Writing 0x5A, 0x52, 0x44 in order to the period register turns the timer off.
// - Codes 0x5A, 0x57, 0x59, 0x53 restart the primary watchdog with 2 s, 1 s, 500 ms, 250 ms.
// - Code 0x5F touches only the secondary timer, never the primary watchdog.
// - Any other command value affects neither watchdog.
module secondary_dog_timer
   import sec_dog_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Avalon-MM slave.
   input  wire logic [3:0]  address_in,
   input  wire logic        read_in,
   input  wire logic        write_in,
   input  wire logic [31:0] writedata_in,
   input  wire logic [3:0]  byteenable_in,
   output logic      [31:0] readdata_out,
   output logic             waitrequest_out,
   // Primary watchdog restart request.
   output logic             pri_restart_out,
   output logic      [1:0]  pri_timeout_out,
   // Interrupt.
   output logic             irq_out,
   output logic      [2:0]  irq_level_out
);

   // Register state.
   logic       enabled;
   logic [7:0] period;
   logic [7:0] count;
   logic [1:0] status;
   logic [1:0] mask;
   logic       tick;
   logic [31:0] tick_acc;
   logic       rd_done;
   seq_state_t seq;

   // Decoded strobes.
   logic       wr_low;
   logic       wr_cmd;
   logic       wr_per;
   logic       wr_stat;
   logic       wr_mask;
   logic       sec_restart;
   logic       expire;
   logic       seq_done;
   logic [7:0] wbyte;

   // Address match shared by every register write strobe.
   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] target);
      return addr == target;
   endfunction

   // Writes complete at once; reads take one wait cycle to register data.
   assign waitrequest_out = read_in & ~rd_done;
   assign wbyte   = writedata_in[7:0];
   assign wr_low  = write_in & byteenable_in[0];
   assign wr_cmd  = wr_low & reg_hit(address_in, ADDR_COMMAND);
   assign wr_per  = wr_low & reg_hit(address_in, ADDR_PERIOD);
   assign wr_stat = wr_low & reg_hit(address_in, ADDR_STATUS);
   assign wr_mask = wr_low & reg_hit(address_in, ADDR_MASK);
   assign sec_restart = wr_cmd & (wbyte == CMD_SEC_RESTART);
   assign expire   = enabled & tick & (count == 8'h00) & ~sec_restart;
   assign seq_done = wr_per & (seq == SEQ_TWO) & (wbyte == OFF_KEY_3);

   // Fractional divider making one 32.768 kHz enable pulse.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tick_acc <= 32'h00000000;
         tick     <= 1'b0;
      end else if (tick_acc + TICK_STEP >= TICK_MODULO) begin
         tick_acc <= tick_acc + TICK_STEP - TICK_MODULO;
         tick     <= 1'b1;
      end else begin
         tick_acc <= tick_acc + TICK_STEP;
         tick     <= 1'b0;
      end
   end

   // Enable flag: off after reset, on by restart code, off by the key sequence.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         enabled <= 1'b0;
      end else if (sec_restart) begin
         enabled <= 1'b1;
      end else if (seq_done) begin
         enabled <= 1'b0;
      end
   end

   // Down counter with reload of the current constant at zero.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         count <= 8'h00;
      end else if (sec_restart) begin
         count <= period;
      end else if (enabled & tick) begin
         if (count == 8'h00) begin
            count <= period;
         end else begin
            count <= count - 8'h01;
         end
      end
   end

   // Period constant register; the counter only samples it at reload.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         period <= PERIOD_RESET;
      end else if (wr_per) begin
         period <= wbyte;
      end
   end

   // Disable key detector; any other value restarts detection.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         seq <= SEQ_IDLE;
      end else if (wr_per) begin
         case (seq)
            SEQ_IDLE: seq <= (wbyte == OFF_KEY_1) ? SEQ_ONE : SEQ_IDLE;
            SEQ_ONE: begin
               if (wbyte == OFF_KEY_2) begin
                  seq <= SEQ_TWO;
               end else begin
                  seq <= (wbyte == OFF_KEY_1) ? SEQ_ONE : SEQ_IDLE;
               end
            end
            SEQ_TWO: seq <= (wbyte == OFF_KEY_1) ? SEQ_ONE : SEQ_IDLE;
            default: seq <= SEQ_IDLE;
         endcase
      end
   end

   // Primary watchdog restart pulse and time-out selection.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pri_restart_out <= 1'b0;
         pri_timeout_out <= PRI_SEL_2S;
      end else begin
         pri_restart_out <= 1'b0;
         if (wr_cmd) begin
            case (wbyte)
               CMD_PRI_2S: begin
                  pri_restart_out <= 1'b1;
                  pri_timeout_out <= PRI_SEL_2S;
               end
               CMD_PRI_1S: begin
                  pri_restart_out <= 1'b1;
                  pri_timeout_out <= PRI_SEL_1S;
               end
               CMD_PRI_500MS: begin
                  pri_restart_out <= 1'b1;
                  pri_timeout_out <= PRI_SEL_500MS;
               end
               CMD_PRI_250MS: begin
                  pri_restart_out <= 1'b1;
                  pri_timeout_out <= PRI_SEL_250MS;
               end
               default: pri_restart_out <= 1'b0;
            endcase
         end
      end
   end

   // Sticky status: set wins over a write-one clear in the same cycle.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         status <= 2'h0;
      end else begin
         status[STAT_EXPIRE] <= expire | (status[STAT_EXPIRE] & ~(wr_stat & wbyte[STAT_EXPIRE]));
         status[STAT_OFF]    <= seq_done | (status[STAT_OFF] & ~(wr_stat & wbyte[STAT_OFF]));
      end
   end

   // Interrupt mask register.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mask <= 2'h0;
      end else if (wr_mask) begin
         mask <= wbyte[1:0];
      end
   end

   // Level interrupt, fixed priority level 3.
   assign irq_out       = |(status & mask);
   assign irq_level_out = IRQ_LEVEL;

   // Read data register; unmapped and write-only addresses read zero.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         readdata_out <= 32'h00000000;
         rd_done      <= 1'b0;
      end else begin
         rd_done <= read_in & ~rd_done;
         if (read_in & ~rd_done) begin
            case (address_in)
               ADDR_PERIOD: readdata_out <= {24'h000000, period};
               ADDR_STATUS: readdata_out <= {23'h000000, enabled, 6'h00, status};
               ADDR_MASK:   readdata_out <= {30'h00000000, mask};
               default:     readdata_out <= 32'h00000000;
            endcase
         end
      end
   end

   // Tick spacing bounds: the fractional divider gives gaps of 1220 or 1221 cycles.
   localparam logic [11:0] TICK_SPAN_LO = 12'h4C3;
   localparam logic [11:0] TICK_SPAN_HI = 12'h4C5;
   logic [11:0] since_tick;

   // Cycles since the last tick, read only by the tick spacing check.
   always_ff @(posedge clk_in) begin
      if (rst_in | tick) begin
         since_tick <= 12'h000;
      end else begin
         since_tick <= since_tick + 12'h001;
      end
   end

   // Counter steps down by one per tick while enabled.
   count_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (enabled && tick && !sec_restart && count != 8'h00) |=> count == $past(count) - 8'h01)
      else $error("Counter did not step down.");

   // Ticks arrive at the 32.768 kHz spacing.
   tick_span_a: assert property (@(posedge clk_in) disable iff (rst_in)
      tick |-> (since_tick >= TICK_SPAN_LO) && (since_tick <= TICK_SPAN_HI))
      else $error("Tick spacing out of range.");

   // Reset leaves the timer off and the interrupt low.
   reset_off_a: assert property (@(posedge clk_in)
      rst_in |=> !enabled && !irq_out)
      else $error("Timer not off after reset.");

   // The restart code switches the timer on.
   enable_cmd_a: assert property (@(posedge clk_in) disable iff (rst_in)
      sec_restart |=> enabled)
      else $error("Restart code did not enable.");

   // A restart reloads the count and raises no expiry.
   restart_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
      sec_restart |=> count == $past(period) && $stable(status[STAT_EXPIRE]))
      else $error("Restart did not reload the count.");

   // Expiry sets the sticky status bit.
   expire_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
      expire |=> status[STAT_EXPIRE])
      else $error("Expiry not flagged.");

   // Writing one clears the expiry bit when no new expiry arrives.
   status_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_stat && wbyte[STAT_EXPIRE] && !expire) |=> !status[STAT_EXPIRE])
      else $error("Expiry bit not cleared.");

   // A period write between ticks leaves the count alone.
   count_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_per && !tick && !sec_restart) |=> count == $past(count))
      else $error("Period write disturbed the count.");

   // Zero reloads the current constant.
   reload_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (enabled && tick && !sec_restart && count == 8'h00) |=> count == $past(period))
      else $error("Counter did not reload at zero.");

   // The full key sequence switches the timer off.
   key_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (seq_done && !sec_restart) |=> !enabled)
      else $error("Key sequence did not disable.");

   // The key sequence also sets the off status bit.
   off_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
      seq_done |=> status[STAT_OFF])
      else $error("Off status not flagged.");

   // The second key advances the detector.
   key_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_per && seq == SEQ_ONE && wbyte == OFF_KEY_2) |=> seq == SEQ_TWO)
      else $error("Second key not accepted.");

   // The secondary code never restarts the primary watchdog.
   pri_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_cmd && wbyte == CMD_SEC_RESTART) |=> !pri_restart_out)
      else $error("Secondary code restarted primary.");

   // Two second primary restart.
   pri_2s_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_cmd && wbyte == CMD_PRI_2S) |=> pri_restart_out && pri_timeout_out == PRI_SEL_2S)
      else $error("Wrong two second time-out.");

   // One second primary restart.
   pri_1s_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_cmd && wbyte == CMD_PRI_1S) |=> pri_restart_out && pri_timeout_out == PRI_SEL_1S)
      else $error("Wrong one second time-out.");

   // Half second primary restart.
   pri_half_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_cmd && wbyte == CMD_PRI_500MS) |=> pri_restart_out && pri_timeout_out == PRI_SEL_500MS)
      else $error("Wrong half second time-out.");

   // Quarter second primary restart.
   pri_map_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_cmd && wbyte == CMD_PRI_250MS) |=> pri_restart_out && pri_timeout_out == PRI_SEL_250MS)
      else $error("Wrong primary time-out.");

   // Undefined code 0x00 touches neither watchdog.
   other_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_cmd && wbyte == 8'h00) |=> !pri_restart_out && $stable(enabled))
      else $error("Undefined code had an effect.");

   // A stray value restarts key detection.
   key_break_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_per && seq == SEQ_ONE && wbyte != OFF_KEY_2 && wbyte != OFF_KEY_1) |=> seq == SEQ_IDLE)
      else $error("Sequence not restarted.");

   // A new read is held off for one cycle.
   read_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (read_in && !rd_done) |-> waitrequest_out)
      else $error("Read not held off.");

   // The held read is answered in its second cycle.
   read_done_a: assert property (@(posedge clk_in) disable iff (rst_in)
      rd_done |-> !waitrequest_out)
      else $error("Read not answered.");

   // Main scenarios: expiry, key disable, primary restart, live restart, period change.
   expire_seen_c: cover property (@(posedge clk_in) disable iff (rst_in) expire);
   key_off_c: cover property (@(posedge clk_in) disable iff (rst_in) seq_done);
   pri_restart_c: cover property (@(posedge clk_in) disable iff (rst_in) pri_restart_out);
   live_restart_c: cover property (@(posedge clk_in) disable iff (rst_in) sec_restart && enabled);
   period_live_c: cover property (@(posedge clk_in) disable iff (rst_in) wr_per && enabled);

endmodule
`default_nettype wire

/* File: sim/secondary_watchdog_timer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module secondary_watchdog_timer_tb
   import sec_dog_pkg::*;
   ;
   // Stimulus and observed ports.
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [3:0]  address_in = 4'h0;
   logic        read_in = 1'b0;
   logic        write_in = 1'b0;
   logic [31:0] writedata_in = 32'h0;
   logic [3:0]  byteenable_in = 4'hF;
   logic [31:0] readdata_out;
   logic        waitrequest_out;
   logic        pri_restart_out;
   logic [1:0]  pri_timeout_out;
   logic        irq_out;
   logic [2:0]  irq_level_out;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          t0, t1;
   logic [31:0] rd;
   int          pulses = 0;
   int          p0;
   logic [1:0]  last_sel = 2'h0;
   // Command codes beside the primary restart they should cause.
   typedef struct {logic [7:0] code; logic pulse; logic [1:0] sel;} row_t;
   row_t rows [8] = '{'{CMD_PRI_2S, 1'b1, PRI_SEL_2S}, '{CMD_PRI_1S, 1'b1, PRI_SEL_1S},
      '{CMD_PRI_500MS, 1'b1, PRI_SEL_500MS}, '{CMD_PRI_250MS, 1'b1, PRI_SEL_250MS},
      '{CMD_SEC_RESTART, 1'b0, 2'h0}, '{8'h00, 1'b0, 2'h0}, '{8'h5B, 1'b0, 2'h0},
      '{8'hFF, 1'b0, 2'h0}};

   secondary_dog_timer u_secondary_dog_timer (.clk_in(clk_in), .rst_in(rst_in),
      .address_in(address_in), .read_in(read_in), .write_in(write_in),
      .writedata_in(writedata_in), .byteenable_in(byteenable_in), .readdata_out(readdata_out),
      .waitrequest_out(waitrequest_out), .pri_restart_out(pri_restart_out),
      .pri_timeout_out(pri_timeout_out), .irq_out(irq_out), .irq_level_out(irq_level_out));

   // Clock of 25 ns and a free cycle count for interval measurements.
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) cyc <= cyc + 1;

   // Counts primary restart pulses and keeps the last selector, sampled mid-cycle.
   always @(negedge clk_in) begin
      if (pri_restart_out === 1'b1) begin
         pulses <= pulses + 1;
         last_sel <= pri_timeout_out;
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One Avalon-MM transfer, held until waitrequest is sampled low, then one idle cycle.
   task automatic bus(input logic rd_en, input logic [3:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      address_in <= addr;
      read_in <= rd_en;
      write_in <= !rd_en;
      writedata_in <= data;
      // Waitrequest and read data are looked at mid-cycle, where they are settled.
      @(negedge clk_in);
      while (waitrequest_out !== 1'b0) begin
         @(negedge clk_in);
         n++;
      end
      rd = readdata_out;
      // The request is accepted at this rising edge and released just after it.
      @(posedge clk_in);
      read_in <= 1'b0;
      write_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic wr(input logic [3:0] addr, input logic [31:0] data);
      bus(1'b0, addr, data);
   endtask

   task automatic rdchk(input string name, input logic [3:0] addr, input logic [31:0] exp);
      bus(1'b1, addr, 32'h0);
      check(name, rd, exp);
   endtask

   // Waits for the interrupt line and returns the cycle at which it was seen.
   task automatic wait_irq(output int t);
      int n;
      n = 0;
      while (irq_out !== 1'b1 && n < 5000) begin
         @(posedge clk_in);
         n++;
      end
      if (n >= 5000) fail_count++;
      t = cyc;
   endtask

   task automatic gap(input string name, input int d, input int lo, input int hi);
      check(name, 32'((d >= lo) && (d <= hi)), 32'h1);
   endtask

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Main sequence: reset, command table, then timing and disable cases.
   initial begin
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      rdchk("status", ADDR_STATUS, 32'h0);
      rdchk("period", ADDR_PERIOD, {24'h0, PERIOD_RESET});
      wr(ADDR_MASK, 32'h3);
      repeat (2600) @(posedge clk_in);
      rdchk("idle status", ADDR_STATUS, 32'h0);
      check("irq idle", irq_out, 1'b0);
      check("irq level", irq_level_out, IRQ_LEVEL);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         p0 = pulses;
         wr(ADDR_COMMAND, {24'h0, rows[i].code});
         check("restart", 32'(pulses - p0), 32'(rows[i].pulse));
         if (rows[i].pulse) check("timeout", last_sel, rows[i].sel);
         @(posedge clk_in);
         check("restart end", pri_restart_out, 1'b0);
      end
      $display("test command table done");
      wr(ADDR_PERIOD, 32'h2);
      wr(ADDR_COMMAND, {24'h0, CMD_SEC_RESTART});
      t0 = cyc;
      wr(ADDR_STATUS, 32'h3);
      rdchk("enabled", ADDR_STATUS, 32'h100);
      wait_irq(t1);
      gap("first expiry", t1 - t0, 2430, 3670);
      rdchk("expired", ADDR_STATUS, 32'h101);
      wr(ADDR_STATUS, 32'h1);
      wait_irq(t0);
      gap("period three ticks", t0 - t1, 3659, 3665);
      wr(ADDR_PERIOD, 32'h0);
      wr(ADDR_STATUS, 32'h1);
      wait_irq(t1);
      gap("old constant kept", t1 - t0, 3659, 3665);
      wr(ADDR_STATUS, 32'h1);
      wait_irq(t0);
      gap("constant zero", t0 - t1, 1219, 1223);
      $display("test expiry done");
      wr(ADDR_PERIOD, 32'h2);
      wr(ADDR_COMMAND, {24'h0, CMD_SEC_RESTART});
      wr(ADDR_STATUS, 32'h1);
      repeat (4) begin
         repeat (2000) @(posedge clk_in);
         wr(ADDR_COMMAND, {24'h0, CMD_SEC_RESTART});
      end
      rdchk("kept alive", ADDR_STATUS, 32'h100);
      check("irq kept low", irq_out, 1'b0);
      $display("test restart done");
      foreach (rows[i]) if (i < 4) wr(ADDR_PERIOD, {24'h0, 8'(i == 2 ? 8'h00 : 8'h5A + 8'(i))});
      rdchk("broken key", ADDR_STATUS, 32'h100);
      wr(ADDR_PERIOD, {24'h0, OFF_KEY_1});
      wr(ADDR_PERIOD, {24'h0, OFF_KEY_2});
      wr(ADDR_PERIOD, {24'h0, OFF_KEY_3});
      rdchk("disabled", ADDR_STATUS, 32'h2);
      check("irq off flag", irq_out, 1'b1);
      wr(ADDR_MASK, 32'h1);
      check("irq masked", irq_out, 1'b0);
      wr(ADDR_STATUS, 32'h2);
      wr(ADDR_MASK, 32'h3);
      repeat (4000) @(posedge clk_in);
      rdchk("stays off", ADDR_STATUS, 32'h0);
      wr(ADDR_COMMAND, {24'h0, CMD_SEC_RESTART});
      rdchk("enabled again", ADDR_STATUS, 32'h100);
      $display("test disable done");
      byteenable_in <= 4'h0;
      wr(ADDR_PERIOD, 32'h11);
      byteenable_in <= 4'hF;
      rdchk("lane off", ADDR_PERIOD, {24'h0, OFF_KEY_3});
      wr(4'h2, 32'hFF);
      rdchk("unmapped", 4'h2, 32'h0);
      rdchk("command read", ADDR_COMMAND, 32'h0);
      $display("test refusal done");
      finish_test();
   end

   // Watchdog that ends a hung run.
   initial begin
      #(25 * 80000);
      fail_count++;
      finish_test();
   end
endmodule
`default_nettype wire
